// ### wbl_pkg.sv
// package: constants, types and register map of the work bit engine
package wbl_pkg;

    localparam int NUM_WB  = 8;
    localparam int NUM_EVD = 4;
    localparam int SEL_W   = 6;
    localparam int DLY_W   = 14;
    localparam int EVD_W   = 4;

    // delay settings run 0 to 9999 time units
    localparam logic [DLY_W-1:0] DLY_MAX = 14'h270f;

    // time base: seconds at the 40 MHz core clock, minutes from seconds
    localparam int CLK_FREQ_HZ = 40_000_000;
    localparam int UNIT_SEC_S  = 1;
    localparam int CYC_PER_SEC = CLK_FREQ_HZ * UNIT_SEC_S;
    localparam logic [5:0] SEC_PER_MIN = 6'h3c;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_EVSEL  = 8'h08;
    localparam logic [7:0] OFS_CFG    = 8'h20;
    localparam logic [7:0] OFS_DLY    = 8'h40;

    // control register fields and reset value
    localparam int CTRL_UNIT_MIN_BIT = 0;
    localparam int CTRL_MSP_LSB      = 4;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;

    // status register fields
    localparam int STS_WB_LSB   = 0;
    localparam int STS_EVD_LSB  = 8;
    localparam int STS_SETT_LSB = 12;

    // condition selector codes, shared by every input of every work bit
    localparam logic [SEL_W-1:0] SEL_OFF        = 6'h00;
    localparam logic [SEL_W-1:0] SEL_ON         = 6'h01;
    localparam logic [SEL_W-1:0] SEL_FIRST      = 6'h02;
    localparam logic [SEL_W-1:0] SEL_EV1        = 6'h03;
    localparam logic [SEL_W-1:0] SEL_EV4        = 6'h06;
    localparam logic [SEL_W-1:0] SEL_ALM1       = 6'h07;
    localparam logic [SEL_W-1:0] SEL_ALM3       = 6'h09;
    localparam logic [SEL_W-1:0] SEL_CNT_ALM    = 6'h0a;
    localparam logic [SEL_W-1:0] SEL_OUT1       = 6'h0b;
    localparam logic [SEL_W-1:0] SEL_OUT2       = 6'h0c;
    localparam logic [SEL_W-1:0] SEL_IN_ERR     = 6'h0d;
    localparam logic [SEL_W-1:0] SEL_HB         = 6'h0f;
    localparam logic [SEL_W-1:0] SEL_HS         = 6'h10;
    localparam logic [SEL_W-1:0] SEL_OC         = 6'h11;
    localparam logic [SEL_W-1:0] SEL_AUTO_MAN   = 6'h12;
    localparam logic [SEL_W-1:0] SEL_RUN_STOP   = 6'h13;
    localparam logic [SEL_W-1:0] SEL_PROG_START = 6'h15;
    localparam logic [SEL_W-1:0] SEL_AUTOTUNE   = 6'h16;
    localparam logic [SEL_W-1:0] SEL_SP_RAMP    = 6'h17;
    localparam logic [SEL_W-1:0] SEL_MSP0       = 6'h18;
    localparam logic [SEL_W-1:0] SEL_MSP1       = 6'h19;
    localparam logic [SEL_W-1:0] SEL_PROG_END   = 6'h1b;
    localparam logic [SEL_W-1:0] SEL_WB1        = 6'h1c;
    localparam logic [SEL_W-1:0] SEL_WB8        = 6'h23;

    // event input data selector codes
    localparam logic [EVD_W-1:0] EVD_NONE = 4'h0;
    localparam logic [EVD_W-1:0] EVD_EV1  = 4'h1;
    localparam logic [EVD_W-1:0] EVD_EV4  = 4'h4;
    localparam logic [EVD_W-1:0] EVD_WB1  = 4'h5;
    localparam logic [EVD_W-1:0] EVD_WB8  = 4'hc;

    typedef enum logic [2:0] {
        OP_NONE,
        OP_AND_OR,
        OP_OR_AND,
        OP_OR4,
        OP_AND4
    } wbl_op_t;

    // one work bit configuration word; reset value all zero
    typedef struct packed {
        logic             out_nc;
        wbl_op_t          op;
        logic [3:0]       in_nc;
        logic [SEL_W-1:0] sel_d;
        logic [SEL_W-1:0] sel_c;
        logic [SEL_W-1:0] sel_b;
        logic [SEL_W-1:0] sel_a;
    } wbl_cfg_t;

    typedef struct packed {
        logic [1:0]       pad_hi;
        logic [DLY_W-1:0] off_dly;
        logic [1:0]       pad_lo;
        logic [DLY_W-1:0] on_dly;
    } wbl_dly_t;

    // controller status flags feeding the condition selectors
    typedef struct packed {
        logic [2:0] alarm;
        logic       cnt_alarm_out1;
        logic       cnt_alarm_out2;
        logic       ctl_out1;
        logic       ctl_out1_current;
        logic       ctl_out2;
        logic       ctl_out2_present;
        logic       input_error;
        logic       heater_burnout_alarm;
        logic       heater_short_alarm;
        logic       heater_overcurrent_alarm;
        logic       auto_manual;
        logic       run_stop;
        logic       program_start;
        logic       autotune_command;
        logic       setpoint_ramp;
        logic [1:0] multi_setpoint_select;
        logic       program_end;
    } wbl_status_t;

endpackage

// ### wbl_engine.sv
// work bit logic engine with its APB register file
//
// Function
// - eight independent work bits, each recomputed as one logic value
// - operation type defaults to no operation, which always gives OFF
// - work bit results drive outputs and status switching
// - type 1 is (A and B) or (C and D)
// - type 2 is (A or C) and (B or D)
// - type 4 is A and B and C and D
// - codes 0,1,2 give OFF, ON, ON in first cycle after power-up
// - codes 3-6 event inputs 1-4, codes 7-9 alarms 1-3
// - 13 input error, 15-17 heater alarms, 14 disabled
// - codes 18-27 pick controller modes in the documented order
// - one shared selector encoding, codes 28-35 feed back work bits
// - code 10 is the OR of both output switching count alarms
// - code 11 is control output 1, OFF when it is a current output
// - code 12 is control output 2, OFF when that output is absent
// - each condition input has its own normally open/closed setting
// - normally closed output setting inverts the combined result
// - rising result turns output ON after ON delay 0-9999, 0 off
// - falling result turns output OFF after OFF delay 0-9999, 0 off
// - delay unit is seconds or minutes, seconds by default
// - number of multi-setpoint bits in use is 0 to 2
// - event data selectors: 0 none, 1-4 events, 5-12 work bits
// - nonzero event data selection makes its assignment settable
//
// Added by the designer: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module wbl_engine
    import wbl_pkg::*;
#(
    parameter int unsigned CYC_PER_SEC_P = wbl_pkg::CYC_PER_SEC
) (
    input  wire logic                  core_clk,     // core clock, 40 MHz
    input  wire logic                  nrst,         // async reset, low
    input  wire logic                  psel,         // apb select
    input  wire logic                  penable,      // apb access phase
    input  wire logic                  pwrite,       // apb write
    input  wire logic [7:0]            paddr,        // apb byte address
    input  wire logic [31:0]           pwdata,       // apb write data
    output logic      [31:0]           prdata,       // apb read data
    output logic                       pready,       // apb ready
    output logic                       pslverr,      // apb error
    input  wire wbl_pkg::wbl_status_t  ctl_status,   // controller flags
    input  wire logic [3:0]            event_in,     // event input pins
    output logic      [7:0]            work_bits,    // delayed work bits
    output logic      [3:0]            event_data,   // event data values
    output logic      [3:0]            event_settable // assignment open
);
    import wbl_pkg::*;

    if (CYC_PER_SEC_P < 2) begin : g_chk
        $error("wbl_engine: CYC_PER_SEC_P must be at least 2");
    end

    localparam int PRE_W = $clog2(CYC_PER_SEC_P);
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(CYC_PER_SEC_P - 1);

    // register state
    logic [31:0]      ctrl_ff;
    logic [15:0]      evsel_ff;
    wbl_cfg_t         cfg_ff [NUM_WB];
    wbl_dly_t         dly_ff [NUM_WB];
    logic [7:0]       wb_ff;
    logic [DLY_W-1:0] cnt_ff [NUM_WB];
    logic             first_ff;
    logic [PRE_W-1:0] pre_ff;
    logic [5:0]       min_ff;
    logic [31:0]      prdata_ff;
    logic             pready_ff;
    logic             pslverr_ff;
    logic [3:0]       evd_ff;
    logic [3:0]       sett_ff;

    logic [7:0]       nxt_wb;
    logic [DLY_W-1:0] nxt_cnt [NUM_WB];
    logic [3:0]       nxt_evd;
    logic [3:0]       nxt_sett;
    logic             tick;
    logic             unit_min;
    logic [1:0]       msp_use;
    logic [1:0]       msp_eff;
    logic             acc;
    logic             wr_en;
    logic             hit;
    logic [31:0]      rd_val;

    assign unit_min = ctrl_ff[CTRL_UNIT_MIN_BIT];
    assign msp_use  = ctrl_ff[CTRL_MSP_LSB +: 2];

    // multi-setpoint bits beyond the configured count read OFF
    assign msp_eff[0] = ctl_status.multi_setpoint_select[0]
                        & (msp_use != 2'h0);
    assign msp_eff[1] = ctl_status.multi_setpoint_select[1]
                        & (msp_use >= 2'h2);

    // apb slave
    // one wait state: ready is registered and raised in the second access cycle
    assign acc   = psel & penable & ~pready_ff;
    assign wr_en = acc & pwrite & hit;

    always_comb begin
        hit    = 1'b1;
        rd_val = 32'h0000_0000;
        if (paddr[1:0] != 2'h0) begin
            hit = 1'b0;
        end else if (paddr == OFS_CTRL) begin
            rd_val = {26'h000_0000, ctrl_ff[5:4], 3'h0, ctrl_ff[0]};
        end else if (paddr == OFS_STATUS) begin
            rd_val = {16'h0000, sett_ff, evd_ff, wb_ff};
        end else if (paddr == OFS_EVSEL) begin
            rd_val = {16'h0000, evsel_ff};
        end else if (paddr >= OFS_CFG && paddr < OFS_CFG + 8'h20) begin
            rd_val = cfg_ff[3'(paddr[4:2])];
        end else if (paddr >= OFS_DLY && paddr < OFS_DLY + 8'h20) begin
            rd_val = dly_ff[3'(paddr[4:2])];
        end else begin
            hit = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end else begin
            pready_ff  <= acc;
            pslverr_ff <= acc & ~hit;
            if (acc && !pwrite) begin
                prdata_ff <= rd_val;
            end
        end
    end

    // writes land at the same edge that raises pready; the master then
    // holds the request for one more edge, which is ignored
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_ff  <= CTRL_RST;
            evsel_ff <= 16'h0000;
        end else if (wr_en) begin
            if (paddr == OFS_CTRL) begin
                ctrl_ff <= {26'h000_0000, pwdata[5:4], 3'h0, pwdata[0]};
            end
            if (paddr == OFS_EVSEL) begin
                evsel_ff <= pwdata[15:0];
            end
        end
    end

    // configuration words; all-zero reset means no operation, OFF inputs
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < NUM_WB; i++) begin
                cfg_ff[i] <= '0;
                dly_ff[i] <= '0;
            end
        end else if (wr_en) begin
            if (paddr[7:5] == OFS_CFG[7:5]) begin
                cfg_ff[3'(paddr[4:2])] <= wbl_cfg_t'(pwdata);
            end
            if (paddr[7:5] == OFS_DLY[7:5]) begin
                // out of range delays are clamped to the documented maximum
                dly_ff[3'(paddr[4:2])].on_dly <=
                    (pwdata[13:0] > DLY_MAX) ? DLY_MAX : pwdata[13:0];
                dly_ff[3'(paddr[4:2])].off_dly <=
                    (pwdata[29:16] > DLY_MAX) ? DLY_MAX : pwdata[29:16];
            end
        end
    end

    // time base
    // prescaler free-runs, so a programmed delay of n units lasts
    // between n-1 and n units; the phase of the tick is not resynced
    assign tick = (pre_ff == PRE_LAST)
                  & (~unit_min | (min_ff == SEC_PER_MIN - 6'h01));

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pre_ff <= '0;
            min_ff <= 6'h00;
        end else if (pre_ff == PRE_LAST) begin
            pre_ff <= '0;
            min_ff <= (min_ff == SEC_PER_MIN - 6'h01) ? 6'h00
                                                      : min_ff + 6'h01;
        end else begin
            pre_ff <= pre_ff + PRE_W'(1);
        end
    end

    // first evaluation cycle after power-up
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            first_ff <= 1'b1;
        end else begin
            first_ff <= 1'b0;
        end
    end

    // condition selection
    function automatic logic pick(input logic [SEL_W-1:0] code);
        logic v;
        v = 1'b0;
        if (code >= SEL_EV1 && code <= SEL_EV4) begin
            v = event_in[2'(code - SEL_EV1)];
        end else if (code >= SEL_ALM1 && code <= SEL_ALM3) begin
            v = ctl_status.alarm[2'(code - SEL_ALM1)];
        end else if (code >= SEL_WB1 && code <= SEL_WB8) begin
            v = wb_ff[3'(code - SEL_WB1)];
        end else begin
            case (code)
                SEL_OFF:        v = 1'b0;
                SEL_ON:         v = 1'b1;
                SEL_FIRST:      v = first_ff;
                SEL_CNT_ALM:    v = ctl_status.cnt_alarm_out1
                                    | ctl_status.cnt_alarm_out2;
                SEL_OUT1:       v = ctl_status.ctl_out1
                                    & ~ctl_status.ctl_out1_current;
                SEL_OUT2:       v = ctl_status.ctl_out2
                                    & ctl_status.ctl_out2_present;
                SEL_IN_ERR:     v = ctl_status.input_error;
                SEL_HB:         v = ctl_status.heater_burnout_alarm;
                SEL_HS:         v = ctl_status.heater_short_alarm;
                SEL_OC:         v = ctl_status.heater_overcurrent_alarm;
                SEL_AUTO_MAN:   v = ctl_status.auto_manual;
                SEL_RUN_STOP:   v = ctl_status.run_stop;
                SEL_PROG_START: v = ctl_status.program_start;
                SEL_AUTOTUNE:   v = ctl_status.autotune_command;
                SEL_SP_RAMP:    v = ctl_status.setpoint_ramp;
                SEL_MSP0:       v = msp_eff[0];
                SEL_MSP1:       v = msp_eff[1];
                SEL_PROG_END:   v = ctl_status.program_end;
                // disabled codes 14, 20, 26 and codes above 35 read OFF
                default:        v = 1'b0;
            endcase
        end
        return v;
    endfunction

    // per work bit logic
    for (genvar g = 0; g < NUM_WB; g++) begin : g_wb
        logic [3:0]       cond;
        logic             comb_res;
        logic             target;
        logic [DLY_W-1:0] dly;
        logic [DLY_W:0]   cnt_inc;

        // always_comb, not assign: it also wakes on what pick reads
        always_comb begin
            for (int k = 0; k < 4; k++) begin
                cond[k] = pick(cfg_ff[g][k*SEL_W +: SEL_W])
                          ^ cfg_ff[g].in_nc[k];
            end
        end

        always_comb begin
            unique case (cfg_ff[g].op)
                OP_NONE:   comb_res = 1'b0;
                OP_AND_OR: comb_res = (cond[0] & cond[1])
                                      | (cond[2] & cond[3]);
                OP_OR_AND: comb_res = (cond[0] | cond[2])
                                      & (cond[1] | cond[3]);
                OP_OR4:    comb_res = |cond;
                OP_AND4:   comb_res = &cond;
                default:   comb_res = 1'b0;
            endcase
        end

        // no operation stays OFF even with a normally closed output
        assign target = (cfg_ff[g].op == OP_NONE) ? 1'b0
                        : comb_res ^ cfg_ff[g].out_nc;

        assign dly     = target ? dly_ff[g].on_dly : dly_ff[g].off_dly;
        assign cnt_inc = {1'b0, cnt_ff[g]} + 15'h0001;

        // a pending change that reverts before its delay ends is dropped
        always_comb begin
            nxt_wb[g]  = wb_ff[g];
            nxt_cnt[g] = '0;
            if (target != wb_ff[g]) begin
                if (dly == '0) begin
                    nxt_wb[g] = target;
                end else if (tick) begin
                    if (cnt_inc >= {1'b0, dly}) begin
                        nxt_wb[g] = target;
                    end else begin
                        nxt_cnt[g] = cnt_inc[DLY_W-1:0];
                    end
                end else begin
                    nxt_cnt[g] = cnt_ff[g];
                end
            end
        end
    end

    // all eight bits advance together, so feedback sees last cycle's set
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            wb_ff <= 8'h00;
            for (int i = 0; i < NUM_WB; i++) begin
                cnt_ff[i] <= '0;
            end
        end else begin
            wb_ff <= nxt_wb;
            for (int i = 0; i < NUM_WB; i++) begin
                cnt_ff[i] <= nxt_cnt[i];
            end
        end
    end

    // event input data selectors
    for (genvar e = 0; e < NUM_EVD; e++) begin : g_evd
        logic [EVD_W-1:0] s;
        assign s = evsel_ff[e*EVD_W +: EVD_W];

        always_comb begin
            nxt_evd[e] = 1'b0;
            if (s >= EVD_EV1 && s <= EVD_EV4) begin
                nxt_evd[e] = event_in[2'(s - EVD_EV1)];
            end else if (s >= EVD_WB1 && s <= EVD_WB8) begin
                nxt_evd[e] = wb_ff[3'(s - EVD_WB1)];
            end
        end

        // the terminal need not exist; any assignment opens the function
        assign nxt_sett[e] = (s != EVD_NONE);
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            evd_ff  <= 4'h0;
            sett_ff <= 4'h0;
        end else begin
            evd_ff  <= nxt_evd;
            sett_ff <= nxt_sett;
        end
    end

    assign prdata         = prdata_ff;
    assign pready         = pready_ff;
    assign pslverr        = pslverr_ff;
    assign work_bits      = wb_ff;
    assign event_data     = evd_ff;
    assign event_settable = sett_ff;

endmodule

`default_nettype wire

// ### wbl_engine_checker.sv
// port-level assertions for the work bit engine
`timescale 1ns/1ps
`default_nettype none
module wbl_engine_checker
    import wbl_pkg::*;
#(
    parameter int unsigned CYC_PER_SEC_P = 10
) (
    input wire logic                 core_clk,       // clock
    input wire logic                 nrst,           // reset, low
    input wire logic                 psel,           // apb select
    input wire logic                 penable,        // apb access
    input wire logic                 pwrite,         // apb write
    input wire logic [7:0]           paddr,          // apb address
    input wire logic [31:0]          pwdata,         // apb write data
    input wire logic [31:0]          prdata,         // apb read data
    input wire logic                 pready,         // apb ready
    input wire logic                 pslverr,        // apb error
    input wire wbl_pkg::wbl_status_t ctl_status,     // controller flags
    input wire logic [3:0]           event_in,       // event pins
    input wire logic [7:0]           work_bits,      // work bits
    input wire logic [3:0]           event_data,     // event data
    input wire logic [3:0]           event_settable  // assignment open
);
    logic        take;
    logic        mapped;
    logic [3:0]  set_exp;
    logic [15:0] evsel_ff;
    logic        cfg_seen_ff;
    assign take = psel && penable && !pready && pwrite;
    assign mapped = paddr[1:0] == 2'h0 &&
                    (paddr <= 8'h08 || (paddr >= 8'h20 && paddr < 8'h60));
    assign set_exp = {|evsel_ff[15:12], |evsel_ff[11:8],
                      |evsel_ff[7:4], |evsel_ff[3:0]};
    // shadow of the event selector and of any configuration write
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            evsel_ff <= 16'h0000;
            cfg_seen_ff <= 1'b0;
        end else if (take) begin
            if (paddr == 8'h08)
                evsel_ff <= pwdata[15:0];
            if (paddr >= 8'h20 && paddr < 8'h40)
                cfg_seen_ff <= 1'b1;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    property p_ans; psel && penable && !pready |=> pready; endproperty
    a_ans: assert property (p_ans) else $error("no ready after access");
    property p_pulse; pready |=> !pready; endproperty
    a_pulse: assert property (p_pulse) else $error("ready held too long");
    property p_first; pready |-> $past(psel && penable); endproperty
    a_first: assert property (p_first) else $error("ready without access");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("error outside ready");
    property p_map; pready |-> pslverr == !mapped; endproperty
    a_map: assert property (p_map) else $error("error flag vs address");
    property p_rd0; pready && pslverr && !pwrite |-> prdata == 32'h0;
    endproperty
    a_rd0: assert property (p_rd0) else $error("refused read not zero");
    property p_hold; !$stable(prdata) |-> pready && !pwrite; endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_off; !cfg_seen_ff |-> work_bits == 8'h00; endproperty
    a_off: assert property (p_off) else $error("unset work bit on");
    property p_sett;
        evsel_ff == $past(evsel_ff) && evsel_ff == $past(evsel_ff, 2)
            |-> event_settable == set_exp && (event_data & ~set_exp) == 4'h0;
    endproperty
    a_sett: assert property (p_sett) else $error("settable mismatch");
    c_wr: cover property (take);
    c_err: cover property (pready && pslverr);
    c_wb: cover property (work_bits != 8'h00);
endmodule
bind wbl_engine wbl_engine_checker #(.CYC_PER_SEC_P(CYC_PER_SEC_P)) u_chk (
    .core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ctl_status(ctl_status),
    .event_in(event_in), .work_bits(work_bits), .event_data(event_data),
    .event_settable(event_settable));
`default_nettype wire

// ### wbl_ctl_model.sv
// controller side model: presents status flags and event pins
`timescale 1ns/1ps
`default_nettype none
module wbl_ctl_model
    import wbl_pkg::*;
(
    input  wire logic                 core_clk,   // clock
    input  wire logic                 nrst,       // reset, low
    input  wire wbl_pkg::wbl_status_t stat_req,   // flags to present
    input  wire logic [3:0]           ev_req,     // pins to present
    output var wbl_pkg::wbl_status_t  ctl_status, // flags to engine
    output var logic [3:0]            event_in    // pins to engine
);
    // registered so flag changes land one cycle after a request
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ctl_status <= '0;
            event_in <= 4'h0;
        end else begin
            ctl_status <= stat_req;
            event_in <= ev_req;
        end
    end
endmodule
`default_nettype wire

// ### wbl_engine_tb.sv
// self-checking bench for the work bit engine
`timescale 1ns/1ps
`default_nettype none
module wbl_engine_tb;
    import wbl_pkg::*;
    logic        core_clk = 1'b0, nrst = 1'b0, psel = 1'b0;
    logic        penable = 1'b0, pwrite = 1'b0, pready, pslverr, r;
    logic [7:0]  paddr = 8'h00, work_bits;
    logic [31:0] pwdata = 32'h0, prdata;
    wbl_status_t st_req = '0, ctl_status;
    logic [3:0]  ev_req = 4'h0, event_in, event_data, event_settable;
    logic [32:0] exp_q[$];
    int          miscompares = 0, n_checks = 0, seed = 77, i;
    always #12.5 core_clk = ~core_clk;
    wbl_ctl_model u_mdl (.core_clk(core_clk), .nrst(nrst),
        .stat_req(st_req), .ev_req(ev_req), .ctl_status(ctl_status),
        .event_in(event_in));
    wbl_engine #(.CYC_PER_SEC_P(10)) u_dut (.core_clk(core_clk),
        .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ctl_status(ctl_status), .event_in(event_in),
        .work_bits(work_bits), .event_data(event_data),
        .event_settable(event_settable));
    task automatic check(input string nm, input logic [32:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        exp_q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask
    // let the flags settle before the status read
    task automatic stat(input logic [31:0] e);
        repeat (4) @(posedge core_clk);
        rd(8'h04, {1'b0, e});
    endtask
    function automatic logic opv(logic [2:0] op, logic [3:0] x);
        case (op)
            3'd1: return (x[0] & x[1]) | (x[2] & x[3]);
            3'd2: return (x[0] | x[2]) & (x[1] | x[3]);
            3'd3: return |x;
            3'd4: return &x;
            default: return 1'b0;
        endcase
    endfunction
    function automatic logic selv(int c, wbl_status_t s, logic [3:0] e);
        case (c)
            1, 28: return 1'b1;
            3, 4, 5, 6: return e[c-3];
            7, 8, 9: return s.alarm[c-7];
            10: return s.cnt_alarm_out1 | s.cnt_alarm_out2;
            11: return s.ctl_out1 & !s.ctl_out1_current;
            12: return s.ctl_out2 & s.ctl_out2_present;
            13: return s.input_error;
            15: return s.heater_burnout_alarm;
            16: return s.heater_short_alarm;
            17: return s.heater_overcurrent_alarm;
            18: return s.auto_manual;
            19: return s.run_stop;
            21: return s.program_start;
            22: return s.autotune_command;
            23: return s.setpoint_ramp;
            24, 25: return s.multi_setpoint_select[c-24];
            27: return s.program_end;
            default: return 1'b0;
        endcase
    endfunction
    function automatic logic [31:0] cfg(logic o, logic [2:0] op,
        logic [3:0] nc, logic [5:0] d, c, b, a);
        return {o, op, nc, d, c, b, a};
    endfunction
    always @(posedge core_clk) begin
        if (psel && penable && pready && !pwrite)
            check("prdata", {pslverr, prdata}, exp_q.pop_front());
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        miscompares++;
        conclude();
    end
    initial begin
        logic [2:0] op;
        logic [3:0] nc;
        logic       o;
        repeat (2) @(posedge core_clk);
        nrst <= 1'b1;
        rd(8'h00, 33'h0);
        stat(32'h0);
        rd(8'h20, 33'h0);
        rd(8'h40, 33'h0);
        rd(8'hfc, {1'b1, 32'h0});
        wr_bad: apb(1'b1, 8'h22, 32'hffff_ffff);
        rd(8'h22, {1'b1, 32'h0});
        for (i = 0; i < 24; i++) begin
            op = 3'({$random(seed)} % 5);
            nc = 4'($random(seed));
            o = 1'($random(seed));
            ev_req <= 4'($random(seed));
            apb(1'b1, 8'h20, cfg(o, op, nc, 6'h06, 6'h05, 6'h04, 6'h03));
            r = opv(op, ev_req ^ nc) ^ (o & (op != 3'd0));
            stat({31'h0, r});
        end
        apb(1'b1, 8'h00, 32'h20);
        apb(1'b1, 8'h20, cfg(1'b0, 3'd3, 4'h0, 6'h0, 6'h0, 6'h0, 6'h01));
        for (i = 0; i < 29; i++) begin
            st_req <= wbl_status_t'(21'($random(seed)));
            ev_req <= 4'($random(seed));
            apb(1'b1, 8'h24, cfg(1'b0, 3'd3, 4'h0, 6'h0, 6'h0, 6'h0, 6'(i)));
            stat({30'h0, selv(i, st_req, ev_req), 1'b1});
        end
        ev_req <= 4'h1;
        apb(1'b1, 8'h08, 32'h0000_c051);
        rd(8'h08, {1'b0, 32'h0000_c051});
        stat(32'h0000_b303);
        ev_req <= 4'h0;
        apb(1'b1, 8'h24, 32'h0);
        apb(1'b1, 8'h20, cfg(1'b0, 3'd3, 4'h0, 6'h0, 6'h0, 6'h0, 6'h03));
        apb(1'b1, 8'h40, 32'hffff_ffff);
        rd(8'h40, {1'b0, 32'h270f_270f});
        apb(1'b1, 8'h40, 32'h0002_0003);
        stat(32'h0000_b000);
        ev_req <= 4'h1;
        stat(32'h0000_b100);
        repeat (30) @(posedge core_clk);
        stat(32'h0000_b301);
        ev_req <= 4'h0;
        stat(32'h0000_b201);
        repeat (25) @(posedge core_clk);
        stat(32'h0000_b000);
        @(posedge core_clk);
        conclude();
    end
endmodule
`default_nettype wire
